/* File: hdl/sci_mute_parity_status.sv */
/*
  Serial interface core: AXI4-Lite register slave, baud dividers, oversampled
  receiver with mute and wake-up, parity generation and check, transmitter,
  status flags cleared by status-then-data sequences, and the shared request.
  Assumes i_rx_pin is asynchronous; i_irq_mask and i_halt come from the CPU
  on the same clock.
*/
`timescale 1ns/10ps
module sci_mute_parity_status
  import sci_pkg::*;
(
  input wire logic i_clock, // 10 MHz system clock
  input wire logic i_srst, // Synchronous reset, active high
  input wire axi_req_t i_axi, // AXI4-Lite master to slave
  output axi_rsp_t o_axi, // AXI4-Lite slave to master
  input wire logic i_rx_pin, // Serial receive line
  output logic o_tx_pin, // Serial transmit line
  input wire logic i_irq_mask, // CPU global interrupt mask
  input wire logic i_halt, // CPU in halt mode
  output logic o_irq // Shared interrupt request
);
  logic [7:0] ctrl1_q, ctrl2_q, baud_q, rdr_q, tdr_q;
  logic r8_q, stat_armed_q, idle_armed_q;
  logic transmit_empty_flag_q, tc_q, receive_full_flag_q, idle_q, ovr_q, nf_q, fe_q, pe_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_lane_q;
  axi_rsp_t axi_q;

  // Baud divide PR * TR; PR from two select bits, TR a power of two
  function automatic logic [10:0] div_of(input logic [1:0] p, input logic [2:0] s);
    logic [10:0] pr;
    pr = 11'h001;
    case (p)
      2'h1: pr = 11'h003;
      2'h2: pr = 11'h004;
      2'h3: pr = 11'h00d;
      default: pr = 11'h001;
    endcase
    return pr << s;
  endfunction

  // Parity of the low seven or eight data bits, flipped for odd
  function automatic logic par_of(input logic [8:0] d, input logic m, input logic odd);
    return (m ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction

  wire m_w = ctrl1_q[C1_M];
  wire pce_w = ctrl1_q[C1_PCE];
  wire mute_w = ctrl2_q[C2_RWU];
  wire run_w = !i_halt && !ctrl1_q[C1_DIS]; // Halt stops both dividers

  // Bus strobes
  wire ar_fire = i_axi.arvalid && axi_q.arready;
  wire wr_fire = !axi_q.awready && !axi_q.wready && !axi_q.bvalid;
  wire rd_stat = ar_fire && i_axi.araddr == ADR_STATUS;
  wire rd_data = ar_fire && i_axi.araddr == ADR_DATA;
  wire wr_hit = wr_fire && wr_lane_q;
  wire wr_stat = wr_hit && wr_addr_q == ADR_STATUS;
  wire wr_data = wr_hit && wr_addr_q == ADR_DATA;
  wire wr_c1 = wr_hit && wr_addr_q == ADR_CTRL1;
  wire wr_c2 = wr_hit && wr_addr_q == ADR_CTRL2;
  wire wr_map = wr_addr_q inside {ADR_STATUS, ADR_DATA, ADR_BAUD, ADR_CTRL1, ADR_CTRL2};
  wire rd_map = i_axi.araddr inside {ADR_STATUS, ADR_DATA, ADR_BAUD, ADR_CTRL1, ADR_CTRL2};
  // Second step of the status-then-data clear sequences
  wire rx_clr = stat_armed_q && rd_data;
  wire pe_clr = stat_armed_q && (rd_data || wr_data);
  wire tx_clr = stat_armed_q && wr_data;

  // AXI4-Lite handshakes; address and data latched independently
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      axi_q <= '0;
      axi_q.awready <= 1'b1;
      axi_q.wready <= 1'b1;
      axi_q.arready <= 1'b1;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_lane_q <= 1'b0;
    end else begin
      if (i_axi.awvalid && axi_q.awready) begin
        axi_q.awready <= 1'b0;
        wr_addr_q <= i_axi.awaddr;
      end
      if (i_axi.wvalid && axi_q.wready) begin
        axi_q.wready <= 1'b0;
        wr_data_q <= i_axi.wdata[7:0];
        wr_lane_q <= i_axi.wstrb[0];
      end
      if (wr_fire) begin
        axi_q.bvalid <= 1'b1;
        axi_q.bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      if (axi_q.bvalid && i_axi.bready) begin
        axi_q.bvalid <= 1'b0;
        axi_q.awready <= 1'b1;
        axi_q.wready <= 1'b1;
      end
      if (ar_fire) begin
        axi_q.arready <= 1'b0;
        axi_q.rvalid <= 1'b1;
        axi_q.rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        case (i_axi.araddr)
          ADR_STATUS: axi_q.rdata <= {24'h0, transmit_empty_flag_q, tc_q, receive_full_flag_q, idle_q,
                                      ovr_q, nf_q, fe_q, pe_q};
          ADR_DATA: axi_q.rdata <= {24'h0, rdr_q};
          ADR_BAUD: axi_q.rdata <= {24'h0, baud_q};
          ADR_CTRL1: axi_q.rdata <= {24'h0, r8_q, ctrl1_q[6:0]};
          ADR_CTRL2: axi_q.rdata <= {24'h0, ctrl2_q};
          default: axi_q.rdata <= 32'h0;
        endcase
      end
      if (axi_q.rvalid && i_axi.rready) begin
        axi_q.rvalid <= 1'b0;
        axi_q.arready <= 1'b1;
      end
    end
  end
  assign o_axi = axi_q;

  // Status access arms the clear; a data access disarms it unless a status access comes in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      stat_armed_q <= 1'b0;
    end else if (rd_stat || wr_stat) begin
      stat_armed_q <= 1'b1;
    end else if (rd_data || wr_data) begin
      stat_armed_q <= 1'b0;
    end
  end

  // Baud rate sixteenfold tick dividers, receive and transmit independent
  logic [10:0] rx_div_q, tx_div_q;
  wire [10:0] rx_div = div_of(baud_q[7:6], baud_q[2:0]);
  wire [10:0] tx_div = div_of(baud_q[7:6], baud_q[5:3]);
  wire rx_tick = run_w && rx_div_q >= rx_div - 11'h001;
  wire tx_tick = run_w && tx_div_q >= tx_div - 11'h001;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_div_q <= 11'h000;
      tx_div_q <= 11'h000;
    end else if (run_w) begin
      rx_div_q <= rx_tick ? 11'h000 : rx_div_q + 11'h001;
      tx_div_q <= tx_tick ? 11'h000 : tx_div_q + 11'h001;
    end
  end

  // Pin synchroniser: the level moves once stages two and three agree
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_lvl_q <= rx_s3_q;
      end
    end
  end

  // Receiver bit engine
  rx_state_t rx_st_q;
  logic [3:0] rx_os_q, rx_bit_q;
  logic [8:0] rx_sh_q;
  logic [1:0] votes_q;
  logic rx_noise_q, quiet_q;
  logic [7:0] quiet_cnt_q;
  wire vote = (votes_q[0] & votes_q[1]) | (votes_q[0] & rx_lvl_q) | (votes_q[1] & rx_lvl_q);
  wire split = !(votes_q[0] == votes_q[1] && votes_q[1] == rx_lvl_q);
  wire at_vote = rx_tick && rx_os_q == OS_VOTE;
  wire [3:0] n_bits = m_w ? 4'h9 : 4'h8;
  wire [7:0] frame_ticks = {n_bits + 4'h2, 4'h0};
  wire word_done = at_vote && rx_st_q == RX_STOP;
  wire idle_ev = rx_tick && rx_st_q == RX_IDLE && !rx_lvl_q && quiet_q;
  wire [8:0] word_w = m_w ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
  wire fe_w = !vote; // Bad stop bit; a break lands here too
  wire nf_w = rx_noise_q || split;
  always_ff @(posedge i_clock) begin
    if (i_srst || !ctrl2_q[C2_RE]) begin
      rx_st_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      votes_q <= 2'h3;
      rx_noise_q <= 1'b0;
    end else if (rx_tick) begin
      rx_os_q <= rx_os_q + 4'h1;
      if (rx_os_q >= OS_FIRST_VOTE && rx_os_q < OS_VOTE) begin
        votes_q <= {votes_q[0], rx_lvl_q};
      end
      if (at_vote && rx_st_q != RX_IDLE) begin
        rx_noise_q <= rx_noise_q || split;
      end
      case (rx_st_q)
        RX_IDLE: begin
          rx_os_q <= 4'h1;
          rx_noise_q <= 1'b0;
          if (!rx_lvl_q) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (at_vote && vote) begin
            rx_st_q <= RX_IDLE; // Glitch, not a start bit
          end else if (rx_os_q == OS_LAST) begin
            rx_st_q <= RX_DATA;
            rx_bit_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (at_vote) begin
            rx_sh_q <= {vote, rx_sh_q[8:1]}; // Least significant bit first
            rx_bit_q <= rx_bit_q + 4'h1;
          end
          if (rx_os_q == OS_LAST && rx_bit_q == n_bits) begin
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (at_vote) begin
            rx_st_q <= RX_IDLE; // Leave early so the next start is not missed
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Idle frame: a whole frame of ones, reported at the next start bit
  always_ff @(posedge i_clock) begin
    if (i_srst || !ctrl2_q[C2_RE]) begin
      quiet_cnt_q <= 8'h00;
      quiet_q <= 1'b0;
    end else if (rx_tick) begin
      if (rx_st_q != RX_IDLE || !rx_lvl_q) begin
        quiet_cnt_q <= 8'h00;
        quiet_q <= 1'b0;
      end else if (quiet_cnt_q >= frame_ticks - 8'h01) begin
        quiet_q <= 1'b1;
      end else begin
        quiet_cnt_q <= quiet_cnt_q + 8'h01;
      end
    end
  end

  // Mute, wake-up and acceptance of a received word
  wire msb_w = m_w ? word_w[8] : word_w[7]; // Word MSB, which is the parity slot when parity is on
  wire wake_idle = idle_ev && mute_w && !ctrl1_q[C1_WAKE];
  wire wake_addr = word_done && mute_w && ctrl1_q[C1_WAKE] && msb_w;
  wire accept = word_done && (!mute_w || wake_addr); // Muted words set nothing
  wire par_bad = pce_w && (par_of(word_w, m_w, ctrl1_q[C1_PS]) != msb_w);
  wire load_rdr = accept && !receive_full_flag_q;

  // Control registers; a control two write beats a same-cycle wake
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      baud_q <= BAUD_RST;
    end else begin
      if (wr_c1) begin
        ctrl1_q <= wr_data_q;
      end
      if (wr_hit && wr_addr_q == ADR_BAUD) begin
        baud_q <= wr_data_q;
      end
      if (wr_c2) begin
        ctrl2_q <= wr_data_q; // Can re-mute after an address wake
      end else if (wake_idle || wake_addr) begin
        ctrl2_q[C2_RWU] <= 1'b0;
      end
    end
  end

  // Receive buffer: kept on overrun, the shift register moves on
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdr_q <= 8'h00;
      r8_q <= 1'b0;
    end else if (load_rdr) begin
      rdr_q <= word_w[7:0];
      r8_q <= word_w[8];
    end
  end

  // Receive flags; a set in the clearing cycle wins
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      {receive_full_flag_q, idle_q, ovr_q, nf_q, fe_q, pe_q} <= STATUS_RST[5:0];
      idle_armed_q <= 1'b1;
    end else begin
      receive_full_flag_q <= load_rdr || (receive_full_flag_q && !rx_clr);
      ovr_q <= (accept && receive_full_flag_q) || (ovr_q && !rx_clr);
      nf_q <= (load_rdr && nf_w) || (nf_q && !rx_clr);
      fe_q <= (load_rdr && fe_w) || (fe_q && !rx_clr); // Overrun hides it
      pe_q <= (load_rdr && par_bad) || (pe_q && !pe_clr);
      // Idle flag only when awake, and once per received word
      idle_q <= (idle_ev && !mute_w && idle_armed_q) || (idle_q && !rx_clr);
      if (load_rdr) begin
        idle_armed_q <= 1'b1;
      end else if (idle_ev && !mute_w) begin
        idle_armed_q <= 1'b0;
      end
    end
  end

  // Transmit buffer and transmitter
  tx_state_t tx_st_q;
  logic [3:0] tx_os_q, tx_left_q;
  logic [10:0] tx_sh_q;
  logic te_prev_q, preamble_q;
  wire te_w = ctrl2_q[C2_TE];
  wire [8:0] tx_word = {ctrl1_q[C1_T8], tdr_q};
  wire tx_par = par_of(tx_word, m_w, ctrl1_q[C1_PS]);
  // Parity takes the MSB slot; the written MSB is dropped
  wire [8:0] tx_bits = !pce_w ? tx_word :
                       m_w ? {tx_par, tdr_q} : {1'b0, tx_par, tdr_q[6:0]};
  wire [10:0] tx_frame = m_w ? {1'b1, tx_bits, 1'b0} : {2'h3, tx_bits[7:0], 1'b0};
  wire tx_free = te_w && run_w && tx_st_q == TX_IDLE;
  wire tx_load = tx_free && !ctrl2_q[C2_SBK] && !preamble_q && !transmit_empty_flag_q;
  wire tx_end = tx_tick && tx_st_q == TX_SHIFT && tx_os_q == OS_LAST && tx_left_q == 4'h1;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tx_st_q <= TX_IDLE;
      tx_os_q <= 4'h0;
      tx_left_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      te_prev_q <= 1'b0;
      preamble_q <= 1'b0;
      o_tx_pin <= 1'b1;
    end else begin
      te_prev_q <= te_w;
      // Enabling the transmitter queues one preamble frame
      if (te_w && !te_prev_q) begin
        preamble_q <= 1'b1;
      end else if (tx_free && !ctrl2_q[C2_SBK]) begin
        preamble_q <= 1'b0;
      end
      if (tx_free && (ctrl2_q[C2_SBK] || preamble_q || !transmit_empty_flag_q)) begin
        tx_st_q <= TX_SHIFT;
        tx_os_q <= 4'h0;
        tx_left_q <= n_bits + 4'h2;
        if (ctrl2_q[C2_SBK]) begin
          tx_sh_q <= 11'h000; // Break frame, stop slot low too
        end else if (preamble_q) begin
          tx_sh_q <= 11'h7ff;
        end else begin
          tx_sh_q <= tx_frame;
        end
      end else if (tx_tick && tx_st_q == TX_SHIFT) begin
        tx_os_q <= tx_os_q + 4'h1;
        if (tx_os_q == OS_LAST) begin
          tx_sh_q <= {1'b1, tx_sh_q[10:1]}; // Ones fill; the mark after a break comes from the idle drive of the pin
          tx_left_q <= tx_left_q - 4'h1;
          if (tx_left_q == 4'h1) begin
            tx_st_q <= TX_IDLE;
          end
        end
      end
      o_tx_pin <= tx_st_q == TX_SHIFT ? tx_sh_q[0] : 1'b1;
    end
  end

  // Data register write and the transmit flags
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tdr_q <= 8'h00;
      transmit_empty_flag_q <= STATUS_RST[7];
      tc_q <= STATUS_RST[6];
    end else begin
      if (wr_data) begin
        tdr_q <= wr_data_q;
      end
      transmit_empty_flag_q <= tx_load || (transmit_empty_flag_q && !tx_clr);
      tc_q <= tx_end || (tc_q && !tx_clr);
    end
  end

  // One request for the enabled flags, noise and framing excepted, receive ones held off while muted; it also ends wait mode, while halt blocks it
  wire rx_ev = !mute_w && ((ctrl2_q[C2_RIE] && (receive_full_flag_q || ovr_q)) ||
                           (ctrl2_q[C2_LINE_QUIET_IRQ_ENABLE] && idle_q) ||
                           (ctrl1_q[C1_PIE] && pe_q));
  wire tx_ev = (ctrl2_q[C2_TIE] && transmit_empty_flag_q) || (ctrl2_q[C2_TRANSMIT_DONE_IRQ_ENABLE] && tc_q);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (rx_ev || tx_ev) && !i_irq_mask && !i_halt;
    end
  end
endmodule

/* File: hdl/sci_pkg.sv */
/*
  Shared constants and types for the serial interface receive/status block:
  register indexes and byte addresses, bit positions, reset values,
  oversampling figures, bus response codes, bus carriers and machine states.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package sci_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_DATA = 8'h21;
  localparam logic [7:0] IDX_BAUD = 8'h22;
  localparam logic [7:0] IDX_CTRL1 = 8'h23;
  localparam logic [7:0] IDX_CTRL2 = 8'h24;
  localparam logic [7:0] ADR_STATUS = {IDX_STATUS[5:0], 2'h0};
  localparam logic [7:0] ADR_DATA = {IDX_DATA[5:0], 2'h0};
  localparam logic [7:0] ADR_BAUD = {IDX_BAUD[5:0], 2'h0};
  localparam logic [7:0] ADR_CTRL1 = {IDX_CTRL1[5:0], 2'h0};
  localparam logic [7:0] ADR_CTRL2 = {IDX_CTRL2[5:0], 2'h0};
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // Control one bit positions
  localparam int unsigned C1_T8 = 6;
  localparam int unsigned C1_DIS = 5;
  localparam int unsigned C1_M = 4;
  localparam int unsigned C1_WAKE = 3;
  localparam int unsigned C1_PCE = 2;
  localparam int unsigned C1_PS = 1;
  localparam int unsigned C1_PIE = 0;
  // Control two bit positions
  localparam int unsigned C2_TIE = 7;
  localparam int unsigned C2_TRANSMIT_DONE_IRQ_ENABLE = 6;
  localparam int unsigned C2_RIE = 5;
  localparam int unsigned C2_LINE_QUIET_IRQ_ENABLE = 4;
  localparam int unsigned C2_TE = 3;
  localparam int unsigned C2_RE = 2;
  localparam int unsigned C2_RWU = 1;
  localparam int unsigned C2_SBK = 0;
  // Oversampling: 16 ticks a bit, votes taken at ticks 7, 8 and 9
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_VOTE = 4'h9;
  localparam logic [3:0] OS_FIRST_VOTE = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
endpackage

/* File: testbench/remote_uart.sv */
/*
  Remote transceiver on the serial line: sends 8-bit frames after a quiet
  gap of two frames and collects the frames that the block sends.
  Assumes 16 clocks a bit (baud register at zero) and 8-bit words.
*/
`timescale 1ns/10ps
module remote_uart #(
  parameter int BIT_CLKS = 16 // Clocks per bit
) (
  input wire logic i_clock, // Bench clock
  input wire logic i_line, // Line from the block
  output logic o_line // Line to the block
);
  logic [7:0] got_q[$];
  logic [8:0] shift;
  logic stop_bit = 1'b1; // Stop slot level; low makes a framing error

  initial o_line = 1'b1;

  // Gap long enough to count as idle, then start, data LSB first, stop
  task automatic send(input logic [7:0] w);
    logic [29:0] bits;
    bits = {stop_bit, w, 1'b0, 20'hfffff};
    for (int k = 0; k < 30; k++) begin
      o_line <= bits[k];
      repeat (BIT_CLKS) @(posedge i_clock);
    end
    o_line <= 1'b1; // Back to mark after a low stop slot
  endtask

  // Catch frames: start edge, then samples at mid-bit; the preamble has no start
  always begin
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_clock);
    for (int k = 0; k < 9; k++) begin
      repeat (BIT_CLKS) @(posedge i_clock);
      shift[k] = i_line;
    end
    got_q.push_back(shift[7:0]);
  end
endmodule

/* File: testbench/sci_mute_parity_status_checker.sv */
/*
  Port checker for the serial receive/status block: request gating, halt
  freeze, line level after reset and register bus answer timing.
  Assumes it is bound onto sci_mute_parity_status and sees its ports only.
*/
`timescale 1ns/10ps
module sci_mute_parity_status_checker
  import sci_pkg::*;
(
  input wire logic i_clock, // System clock
  input wire logic i_srst, // Synchronous reset
  input wire axi_req_t i_axi, // Bus request
  input wire axi_rsp_t o_axi, // Bus answer
  input wire logic i_rx_pin, // Serial in
  input wire logic o_tx_pin, // Serial out
  input wire logic i_irq_mask, // Global mask
  input wire logic i_halt, // Halt mode
  input wire logic o_irq // Shared request
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  // Handshake steps; both write channels taken on one edge is the bench's habit
  sequence wr_taken;
    i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
  endsequence
  sequence rd_taken;
    i_axi.arvalid && o_axi.arready;
  endsequence

  chk_mask_blocks_irq: assert property ($past(i_irq_mask) |-> !o_irq)
    else $error("request raised while masked");
  chk_halt_blocks_irq: assert property (i_halt [*2] |-> !o_irq)
    else $error("request raised in halt");
  chk_halt_holds_tx: assert property (i_halt [*3] |=> $stable(o_tx_pin))
    else $error("transmit line moved in halt");
  chk_tx_idle_reset: assert property ($fell(i_srst) |-> o_tx_pin)
    else $error("transmit line not idle after reset");
  chk_write_answer: assert property (wr_taken |-> ##2 o_axi.bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rd_taken |=> o_axi.rvalid)
    else $error("read answer late");
  chk_read_holds: assert property (o_axi.rvalid && !i_axi.rready |=>
    o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read answer dropped before taken");
  chk_upper_zero: assert property (o_axi.rvalid |-> o_axi.rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule
bind sci_mute_parity_status sci_mute_parity_status_checker u_checker (.i_clock(i_clock),
  .i_srst(i_srst), .i_axi(i_axi), .o_axi(o_axi), .i_rx_pin(i_rx_pin), .o_tx_pin(o_tx_pin),
  .i_irq_mask(i_irq_mask), .i_halt(i_halt), .o_irq(o_irq));

/* File: testbench/tb_top.sv */
/*
  Self-checking bench for the serial receive/status block: register bus
  master, flag model, remote transceiver on the line.
  Assumes the baud register stays zero, so one bit lasts 16 clocks.
*/
`timescale 1ns/10ps
module tb_top;
  import sci_pkg::*;
  logic i_clock, i_srst, i_irq_mask, i_halt, rx_line, tx_line, irq;
  axi_req_t req;
  axi_rsp_t rsp;
  int failures = 0, num_checks = 0, cycles = 0, seed = 53;
  logic m_transmit_empty_flag, m_tc, m_receive_full_flag, m_idle, m_or, m_fe, m_pe, m_arm, m_mute, m_wake, m_pce, m_ps;
  logic [7:0] m_buf, d, w;
  logic [1:0] r;

  sci_mute_parity_status u_sci_mute_parity_status (.i_clock(i_clock), .i_srst(i_srst),
    .i_axi(req), .o_axi(rsp), .i_rx_pin(rx_line), .o_tx_pin(tx_line),
    .i_irq_mask(i_irq_mask), .i_halt(i_halt), .o_irq(irq));
  remote_uart u_remote_uart (.i_clock(i_clock), .i_line(tx_line), .o_line(rx_line));

  // Clock and hang limit; frames take about 500 cycles each
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [7:0] rnd();
    return 8'($random(seed));
  endfunction

  function automatic logic [7:0] m_status();
    return {m_transmit_empty_flag, m_tc, m_receive_full_flag, m_idle, m_or, 1'b0, m_fe, m_pe};
  endfunction

  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'h1;
    req.bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge i_clock);
      if (req.awvalid && rsp.awready) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (req.wvalid && rsp.wready) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge i_clock); while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // Read: ready raised one edge late so a waiting answer is seen to hold
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] resp);
    @(posedge i_clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge i_clock); while (!rsp.arready);
    req.arvalid <= 1'b0;
    @(posedge i_clock);
    req.rready <= 1'b1;
    do @(posedge i_clock); while (!rsp.rvalid);
    v = rsp.rdata[7:0];
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Status then data read, then the flags it clears must be gone
  task automatic take_word();
    rd(ADR_STATUS, d, r);
    check("status", m_status(), d);
    rd(ADR_DATA, d, r);
    check("data", m_buf & {~m_pce, 7'h7f}, d & {~m_pce, 7'h7f});
    {m_receive_full_flag, m_idle, m_or, m_fe, m_pe} = 5'h00;
    rd(ADR_STATUS, d, r);
    check("status cleared", m_status(), d);
  endtask

  // One frame from the far side, applied to the flag model
  task automatic rx_word(input logic [7:0] v);
    u_remote_uart.send(v);
    repeat (40) @(posedge i_clock);
    if (m_mute && !m_wake) m_mute = 1'b0;
    else if (m_mute && v[7]) m_mute = 1'b0;
    else if (m_mute) return;
    else if (m_arm) begin
      m_idle = 1'b1;
      m_arm = 1'b0;
    end
    if (m_receive_full_flag) m_or = 1'b1;
    else begin
      m_receive_full_flag = 1'b1;
      m_arm = 1'b1;
      m_buf = v;
      m_pe = m_pce && ((^v) != m_ps);
      m_fe = !u_remote_uart.stop_bit;
    end
  endtask

  // Main sequence
  initial begin
    req = '0;
    i_srst = 1'b1;
    i_irq_mask = 1'b0;
    i_halt = 1'b0;
    {m_receive_full_flag, m_idle, m_or, m_fe, m_pe, m_mute, m_wake, m_pce, m_ps} = 9'h000;
    {m_transmit_empty_flag, m_tc, m_arm} = 3'b111;
    repeat (4) @(posedge i_clock);
    i_srst <= 1'b0;
    rd(ADR_STATUS, d, r);
    check("status reset", STATUS_RST, d);
    wr(ADR_STATUS, 8'h00, r);
    rd(ADR_STATUS, d, r);
    check("status read only", m_status(), d);
    wr(8'hfc, 8'h55, r);
    check("unmapped write", {6'h0, RESP_SLVERR}, {6'h0, r});
    rd(8'hfc, d, r);
    check("unmapped read", {6'h0, RESP_SLVERR}, {6'h0, r});
    wr(ADR_CTRL2, 8'h04, r);
    rx_word(rnd());
    take_word();
    rx_word(rnd());
    rx_word(rnd());
    take_word();
    // Parity even then odd: a bad word raises the request, then a good one
    for (int ps = 0; ps < 2; ps++) begin
      m_pce = 1'b1;
      m_ps = ps[0];
      wr(ADR_CTRL1, {5'h0, 1'b1, ps[0], 1'b1}, r);
      w = rnd();
      rx_word({~((^w[6:0]) ^ ps[0]), w[6:0]});
      repeat (2) @(posedge i_clock);
      check("parity irq", 8'h01, {7'h0, irq});
      i_irq_mask <= 1'b1;
      repeat (3) @(posedge i_clock);
      check("masked irq", 8'h00, {7'h0, irq});
      i_irq_mask <= 1'b0;
      i_halt <= 1'b1;
      repeat (3) @(posedge i_clock);
      check("halt irq", 8'h00, {7'h0, irq});
      i_halt <= 1'b0;
      take_word();
      rx_word({(^w[6:0]) ^ ps[0], w[6:0]});
      take_word();
    end
    // Mute with address mark wake, then with idle line wake
    m_pce = 1'b0;
    m_wake = 1'b1;
    wr(ADR_CTRL1, 8'h08, r);
    wr(ADR_CTRL2, 8'h06, r);
    m_mute = 1'b1;
    rx_word(rnd() & 8'h7f);
    rx_word(rnd() | 8'h80);
    rd(ADR_CTRL2, d, r);
    check("address wake", 8'h04, d);
    take_word();
    m_wake = 1'b0;
    wr(ADR_CTRL1, 8'h00, r);
    wr(ADR_CTRL2, 8'h06, r);
    m_mute = 1'b1;
    rx_word(rnd());
    rd(ADR_CTRL2, d, r);
    check("idle wake", 8'h04, d);
    take_word();
    // Low stop slot: the word is still kept, flagged as a framing error
    u_remote_uart.stop_bit = 1'b0;
    rx_word(rnd());
    u_remote_uart.stop_bit = 1'b1;
    take_word();
    // Transmit with odd parity in the top slot
    wr(ADR_CTRL1, 8'h06, r);
    wr(ADR_CTRL2, 8'h0c, r);
    w = rnd();
    rd(ADR_STATUS, d, r);
    wr(ADR_DATA, w, r);
    while (u_remote_uart.got_q.size() == 0) @(posedge i_clock);
    check("tx frame", {~(^w[6:0]), w[6:0]}, u_remote_uart.got_q.pop_front());
    repeat (40) @(posedge i_clock);
    rd(ADR_STATUS, d, r);
    check("tx done", m_status(), d);
    end_sim();
  end
endmodule
